// file: ssfe_pkg.sv
// constants and types shared by the serial frame engine
`default_nettype none
package ssfe_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_DATA = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_DIV = 4'hC;

  // control word fields
  localparam int CB_EN = 0;
  localparam int CB_MST = 1;
  localparam int CB_POL = 2;
  localparam int CB_PHA = 3;
  localparam int CB_MW = 4;
  localparam int CB_SZ = 8;
  localparam int SZ_W = 4;
  localparam logic [SZ_W-1:0] SZ_RST = 4'h7;
  localparam logic [SZ_W-1:0] SZ_MIN = 4'h3;

  // status word fields
  localparam int SB_TXE = 0;
  localparam int SB_TXF = 1;
  localparam int SB_RXNE = 2;
  localparam int SB_RXF = 3;
  localparam int SB_BUSY = 4;
  localparam int SB_OVR = 5;

  // ****************************************
  // frame shape and timing
  // ****************************************
  localparam int WORD_W = 16;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] MW_CMD_BITS = 5'h08;
  localparam logic [4:0] MW_WAIT_BITS = 5'h01;
  localparam int CORE_PERIOD_NS = 25;
  localparam int SCLK_HALF_NS = 100;
  localparam logic [7:0] DIV_RST = 8'((SCLK_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
  localparam logic [7:0] DIV_MIN = 8'h02;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LEAD = 4'b0010,
    ST_XFER = 4'b0100,
    ST_TAIL = 4'b1000
  } ssfe_st_t;

endpackage
`default_nettype wire

// file: ssfe_fifo_if.sv
// word stream between the engine and one of its fifos
`default_nettype none
interface ssfe_fifo_if #(parameter int W = 16) ();
  logic push;
  logic pop;
  logic full;
  logic empty;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;

  modport user (output push, output pop, output wdata, input full, input empty, input rdata);
  modport store (input push, input pop, input wdata, output full, output empty, output rdata);
endinterface
`default_nettype wire

// file: ssfe_sync.sv
// two-flop synchroniser for the serial pins
`default_nettype none
module ssfe_sync #(
  parameter int N = 3,
  parameter logic [N-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins and their synchronised copies
  input wire logic [N-1:0] d_async,
  output logic [N-1:0] q_sync
);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
  } ssfe_sync_st_t;

  ssfe_sync_st_t q;
  ssfe_sync_st_t d;

  always_comb
  begin
    d.s1 = d_async;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      q <= '{s1: RST_VAL, s2: RST_VAL};
    else
      q <= d;
  end

  assign q_sync = q.s2;

endmodule
`default_nettype wire

// file: ssfe_fifo.sv
// small synchronous fifo behind the serial engine
`default_nettype none
module ssfe_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // storage side of the word stream
  ssfe_fifo_if.store f
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ssfe_fifo_st_t;

  ssfe_fifo_st_t q;
  ssfe_fifo_st_t d;
  logic do_push;
  logic do_pop;

  // push when full and pop when empty are ignored
  always_comb
  begin
    d = q;
    do_push = f.push && (q.cnt != FULL_CNT);
    do_pop = f.pop && (q.cnt != '0);
    if (do_push)
    begin
      d.mem[q.wp] = f.wdata;
      d.wp = q.wp + 1'b1;
    end
    if (do_pop)
      d.rp = q.rp + 1'b1;
    d.cnt = q.cnt + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      q <= '0;
    else
      q <= d;
  end

  assign f.full = (q.cnt == FULL_CNT);
  assign f.empty = (q.cnt == '0);
  assign f.rdata = q.mem[q.rp];

endmodule
`default_nettype wire

// file: ssfe_top.sv
// serial frame engine: four-wire and control-word formats, avalon-mm registers
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`default_nettype none
// Functional notes
// - polarity sets serial clock idle level
// - phase picks first or second capture edge
// - pol/pha high idle: clock high, select high
// - clock pad enabled as master, off as slave
// - enabled with tx data: select and pad low
// - first clock edge half period after select
// - sample rising, change falling in mode 11
// - select rises one period after last capture
// - back-to-back mode 11 keeps select low
// - eight-bit command out, nothing received then
// - response four to sixteen bits long
// - control-word idle: clock low, select high
// - select fall loads shifter, msb out
// - select low all frame, receive ignored early
// - response bits latched on rising clock
// - single frame: result stored, select rises
// - continuous frames: next command follows directly
// - continuous: result stored on following falling edge
// - as slave, sample after select input falls
module ssfe_top
  import ssfe_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter logic [7:0] DIV_DEFAULT = DIV_RST
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // serial link
  output logic serial_clock_out,
  input wire logic serial_clock_in,
  output logic frame_select_out,
  input wire logic frame_select_in,
  output logic serial_tx_line,
  input wire logic serial_rx_line,
  output logic tx_pad_enable_n,
  output logic clock_pad_enable_n
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    ssfe_st_t st;
    logic [5:0] eidx;
    logic [7:0] tmr;
    logic sclk;
    logic fss;
    logic txd;
    logic pad_n;
    logic ctl_n;
    logic [WORD_W-1:0] tx_sh;
    logic [WORD_W-1:0] rx_sh;
    logic sclk_p;
    logic fss_p;
    logic en;
    logic mst;
    logic pol;
    logic pha;
    logic mw;
    logic [SZ_W-1:0] sz;
    logic [7:0] div;
    logic ovr;
    logic wr;
    logic [31:0] rdat;
  } ssfe_top_st_t;

  localparam ssfe_top_st_t ST_RST = '{
    st: ST_IDLE, fss: 1'b1, pad_n: 1'b1, ctl_n: 1'b1, fss_p: 1'b1,
    sz: SZ_RST, div: DIV_DEFAULT, wr: 1'b1, default: '0};

  ssfe_top_st_t q;
  ssfe_top_st_t d;

  ssfe_fifo_if #(.W(WORD_W)) tx_if ();
  ssfe_fifo_if #(.W(WORD_W)) rx_if ();

  logic sclk_s;
  logic fss_s;
  logic rxd_s;
  logic req;
  logic tick;
  logic ev;
  logic lead;
  logic capt;
  logic last;
  logic load;
  logic pha;
  logic pol;
  logic [4:0] nbits;
  logic [4:0] total;
  logic [4:0] bitn;
  logic [31:0] wv;

  // ****************************************
  // helpers
  // ****************************************
  // word length from the size field, never below four bits
  function automatic logic [4:0] bits_of(input logic [SZ_W-1:0] sz);
    bits_of = (sz < SZ_MIN) ? 5'({1'b0, SZ_MIN}) + 5'h01 : 5'({1'b0, sz}) + 5'h01;
  endfunction

  // does this end drive the line during bit b
  function automatic logic is_tx(input logic mw, input logic mst, input logic [4:0] b);
    if (!mw)
      is_tx = 1'b1;
    else if (mst)
      is_tx = (b < MW_CMD_BITS);
    else
      is_tx = (b >= MW_CMD_BITS + MW_WAIT_BITS);
  endfunction

  // does this end capture the line during bit b
  function automatic logic is_rx(input logic mw, input logic mst, input logic [4:0] b);
    if (!mw)
      is_rx = 1'b1;
    else if (mst)
      is_rx = (b >= MW_CMD_BITS + MW_WAIT_BITS);
    else
      is_rx = (b < MW_CMD_BITS);
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      be_merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
  endfunction

  // left-align so the msb leaves first
  function automatic logic [WORD_W-1:0] align(input logic [WORD_W-1:0] w, input logic [4:0] nb);
    align = w << (WORD_BITS - nb);
  endfunction

  // ****************************************
  // pin synchronisers and fifos
  // ****************************************
  // sync link inputs
  ssfe_sync #(.N(3), .RST_VAL(3'h2)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d_async({serial_clock_in, frame_select_in, serial_rx_line}),
    .q_sync({sclk_s, fss_s, rxd_s})
  );

  ssfe_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_txf (
    .clk(clk),
    .rstn(rstn),
    .f(tx_if.store)
  );

  ssfe_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_rxf (
    .clk(clk),
    .rstn(rstn),
    .f(rx_if.store)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    d = q;
    tx_if.push = 1'b0;
    tx_if.pop = 1'b0;
    tx_if.wdata = avs_writedata[WORD_W-1:0];
    rx_if.push = 1'b0;
    rx_if.pop = 1'b0;
    rx_if.wdata = '0;
    wv = '0;
    load = 1'b0;
    req = avs_read || avs_write;
    // the control-word format always runs with idle-low clock, first-edge capture
    pha = q.pha && !q.mw;
    pol = q.pol && !q.mw;
    nbits = bits_of(q.sz);
    total = q.mw ? nbits + MW_CMD_BITS + MW_WAIT_BITS : nbits;
    bitn = q.eidx[5:1];
    lead = !q.eidx[0];
    tick = (q.tmr == '0);
    ev = q.mst ? tick && (q.st == ST_LEAD || q.st == ST_XFER)
               : (q.st == ST_XFER) && !fss_s && (sclk_s != q.sclk_p);
    capt = ev && (lead ^ pha);
    last = (q.eidx == 6'({total, 1'b0}) - 6'h01);
    d.sclk_p = sclk_s;
    d.fss_p = fss_s;
    d.ctl_n = !q.mst;

    // ---- register bus: one wait cycle, then complete ----
    if (!q.wr)
    begin
      d.wr = 1'b1;
      if (avs_write)
      begin
        unique case (avs_address)
          OFS_CTRL:
          begin
            wv = be_merge({20'h0_0000, q.sz, 3'h0, q.mw, q.pha, q.pol, q.mst, q.en},
                          avs_writedata, avs_byteenable);
            d.en = wv[CB_EN];
            d.mst = wv[CB_MST];
            d.pol = wv[CB_POL];
            d.pha = wv[CB_PHA];
            d.mw = wv[CB_MW];
            d.sz = wv[CB_SZ +: SZ_W];
          end
          OFS_DATA:
            tx_if.push = 1'b1;
          OFS_STAT:
            if (avs_byteenable[0] && avs_writedata[SB_OVR])
              d.ovr = 1'b0;
          OFS_DIV:
          begin
            wv = be_merge({24'h00_0000, q.div}, avs_writedata, avs_byteenable);
            d.div = (wv[7:0] < DIV_MIN) ? DIV_MIN : wv[7:0];
          end
          default:
            d.wr = 1'b1;
        endcase
      end
      if (avs_read && avs_address == OFS_DATA)
        rx_if.pop = 1'b1;
    end
    else if (req)
    begin
      d.wr = 1'b0;
      unique case (avs_address)
        OFS_CTRL:
          d.rdat = {20'h0_0000, q.sz, 3'h0, q.mw, q.pha, q.pol, q.mst, q.en};
        OFS_DATA:
          d.rdat = rx_if.empty ? 32'h0000_0000 : {16'h0000, rx_if.rdata};
        OFS_STAT:
          d.rdat = {26'h000_0000, q.ovr, q.st != ST_IDLE, rx_if.full, !rx_if.empty,
                    tx_if.full, tx_if.empty};
        OFS_DIV:
          d.rdat = {24'h00_0000, q.div};
        default:
          d.rdat = 32'h0000_0000;
      endcase
    end

    // ---- half-period timer of the generated clock ----
    if (q.st != ST_IDLE)
      d.tmr = tick ? q.div - 8'h01 : q.tmr - 8'h01;

    // ---- frame engine ----
    unique case (q.st)
      ST_IDLE:
      begin
        d.sclk = pol;
        if (q.en && q.mst && !tx_if.empty)
        begin
          d.st = ST_LEAD;
          d.fss = 1'b0;
          d.pad_n = 1'b0;
          d.tmr = q.div - 8'h01;
          load = 1'b1;
        end
        // frame start as slave on select fall
        else if (q.en && !q.mst && !fss_s && q.fss_p)
        begin
          d.st = ST_XFER;
          d.pad_n = 1'b0;
          load = 1'b1;
        end
      end
      ST_LEAD, ST_XFER:
      begin
        if (!q.mst && fss_s)
        begin
          d.st = ST_IDLE;
          d.pad_n = 1'b1;
          d.txd = 1'b0;
        end
        else if (ev)
        begin
          // first transition ends the lead-in half period
          d.st = ST_XFER;
          d.eidx = q.eidx + 6'h01;
          if (q.mst)
            d.sclk = !q.sclk;
          // capture only on own receive bits
          if (capt && is_rx(q.mw, q.mst, bitn))
            d.rx_sh = {q.rx_sh[WORD_W-2:0], rxd_s};
          // second-edge phase changes data on leading edges
          if (pha && lead)
          begin
            d.txd = q.tx_sh[WORD_W-1];
            d.tx_sh = q.tx_sh << 1;
          end
          // command then wait bit then response, msb first
          if (!pha && !lead)
          begin
            if (is_tx(q.mw, q.mst, bitn))
              d.tx_sh = q.tx_sh << 1;
            d.txd = is_tx(q.mw, q.mst, bitn + 5'h01) ? d.tx_sh[WORD_W-1] : 1'b0;
          end
          if (last)
          begin
            rx_if.push = 1'b1;
            rx_if.wdata = d.rx_sh;
            if (rx_if.full)
              d.ovr = 1'b1;
            if (!q.mst || (!tx_if.empty && (q.mw || pha)))
              load = 1'b1;
            else
            begin
              // select rises one period after last capture
              d.st = ST_TAIL;
              d.eidx = pha ? 6'h01 : 6'h00;
            end
          end
        end
      end
      ST_TAIL:
      begin
        if (tick)
        begin
          if (q.eidx == '0)
          begin
            d.st = ST_IDLE;
            d.fss = 1'b1;
            d.pad_n = 1'b1;
            d.txd = 1'b0;
          end
          else
            d.eidx = q.eidx - 6'h01;
        end
      end
    endcase

    // shifter load, msb shown at once for first-edge phase
    if (load)
    begin
      tx_if.pop = !tx_if.empty;
      d.tx_sh = tx_if.empty ? '0
              : align(tx_if.rdata, (q.mw && q.mst) ? MW_CMD_BITS : nbits);
      d.rx_sh = '0;
      d.eidx = '0;
      // second-edge phase holds the last bit: this edge is the far end's capture edge
      d.txd = (!pha && is_tx(q.mw, q.mst, 5'h00)) ? d.tx_sh[WORD_W-1] : pha && q.txd;
    end

    // disabling aborts any frame; a partial word is dropped
    if (!q.en)
    begin
      d.st = ST_IDLE;
      d.fss = 1'b1;
      d.pad_n = 1'b1;
      d.txd = 1'b0;
      d.sclk = pol;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      q <= ST_RST;
    else
      q <= d;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign avs_readdata = q.rdat;
  assign avs_waitrequest = q.wr;
  assign serial_clock_out = q.sclk;
  assign frame_select_out = q.fss;
  assign serial_tx_line = q.txd;
  assign tx_pad_enable_n = q.pad_n;
  assign clock_pad_enable_n = q.ctl_n;

endmodule
`default_nettype wire

// file: ssfe_chk.sv
// port checker for the serial frame engine
`default_nettype none
module ssfe_chk
  import ssfe_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // serial link
  input wire logic serial_clock_out,
  input wire logic frame_select_out,
  input wire logic serial_tx_line,
  input wire logic tx_pad_enable_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // *****
  // properties
  // *****
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low twice");
  property p_wait_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no bus answer");
  property p_idle_tx;
    tx_pad_enable_n |-> !serial_tx_line;
  endproperty
  a_idle_tx: assert property (p_idle_tx) else $error("idle tx high");
  property p_start;
    $fell(frame_select_out) |-> $fell(tx_pad_enable_n);
  endproperty
  a_start: assert property (p_start) else $error("pad not with select");
  property p_pad;
    !frame_select_out |-> !tx_pad_enable_n;
  endproperty
  a_pad: assert property (p_pad) else $error("pad off in frame");
  // at the default divider the first clock edge is four core cycles late
  property p_first;
    $fell(frame_select_out) |-> $stable(serial_clock_out)[*3] ##[1:3] $changed(serial_clock_out);
  endproperty
  a_first: assert property (p_first) else $error("first edge timing");
  property p_hold;
    $changed(serial_tx_line) && !tx_pad_enable_n && !$past(tx_pad_enable_n)
      |-> !$rose(serial_clock_out);
  endproperty
  a_hold: assert property (p_hold) else $error("tx moved on capture");
  property p_end;
    $rose(frame_select_out)
      |-> $rose(tx_pad_enable_n) && serial_clock_out == $past(serial_clock_out, 3);
  endproperty
  a_end: assert property (p_end) else $error("frame end timing");
  c_frame: cover property ($fell(frame_select_out));
  c_end: cover property ($rose(frame_select_out));
  c_write: cover property (avs_write && !avs_waitrequest);
endmodule
bind ssfe_top ssfe_chk ssfe_chk_i (.clk(clk), .rstn(rstn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .serial_clock_out(serial_clock_out), .frame_select_out(frame_select_out),
  .serial_tx_line(serial_tx_line), .tx_pad_enable_n(tx_pad_enable_n));
`default_nettype wire

// file: ssfe_partner.sv
// behavioural serial slave facing the engine in master mode
`default_nettype none
module ssfe_partner (
  // link from the engine
  input wire logic serial_clock_out,
  input wire logic frame_select_out,
  input wire logic serial_tx_line,
  // scenario settings
  input wire logic cw,
  input wire logic [4:0] nresp,
  input wire logic [31:0] resp,
  // link back and captured bits
  output logic serial_rx_line,
  output logic [31:0] cap
);
  timeunit 1ns;
  timeprecision 1ps;
  int nfall = 0;
  int pos;
  logic last = 1'b0;
  initial serial_rx_line = 1'b1;
  always @(negedge frame_select_out)
  begin
    nfall = 0;
    cap = '0;
  end
  always @(posedge serial_clock_out)
    if (!frame_select_out) cap <= {cap[30:0], serial_tx_line};
  always @(negedge serial_clock_out or posedge frame_select_out)
  begin
    if (frame_select_out)
      serial_rx_line <= ~last;
    else
    begin
      nfall = nfall + 1;
      // control-word frames skip eight command bits and the wait bit
      pos = cw ? (nfall - 1) % (9 + int'(nresp)) - 8 : nfall - 1;
      if (pos >= 0 && pos < (cw ? int'(nresp) : 32))
      begin
        last = resp[31 - pos];
        serial_rx_line <= last;
      end
      else
        serial_rx_line <= ~last;
    end
  end
endmodule
`default_nettype wire

// file: tb_ssfe_top.sv
// self-checking bench for the serial frame engine
`default_nettype none
module tb_ssfe_top
  import ssfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = '0;
  logic [31:0] rdat, got, cap;
  logic wreq, sclk, fso, txd, rxd, prx, txoe, ckoe;
  logic sci = 1'b1;
  logic fsi = 1'b1;
  logic srx = 1'b0;
  logic slv = 1'b0;
  logic cw = 1'b0;
  logic [4:0] nr = 5'h10;
  logic [31:0] resp = 32'hA5C3_3C5A;
  int n_fail = 0;
  int n_checks = 0;
  int nrise = 0;
  assign rxd = slv ? srx : prx;
  initial forever #12.5 clk = ~clk;
  always @(posedge fso) nrise++;
  ssfe_top ssfe_top_i (.clk(clk), .rstn(rstn), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .serial_clock_out(sclk), .serial_clock_in(sci),
    .frame_select_out(fso), .frame_select_in(fsi), .serial_tx_line(txd),
    .serial_rx_line(rxd), .tx_pad_enable_n(txoe), .clock_pad_enable_n(ckoe));
  ssfe_partner ssfe_partner_i (.serial_clock_out(sclk), .frame_select_out(fso),
    .serial_tx_line(txd), .cw(cw), .nresp(nr), .resp(resp), .serial_rx_line(prx),
    .cap(cap));
  // *****
  // tasks
  // *****
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic hang(input string m);
    n_fail++;
    $display("unexpected at %0t: %s timeout", $time, m);
    tally_and_finish;
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    if (n >= 50) hang("bus");
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdv(input logic [3:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, '0);
    chk(got, e, m);
  endtask
  task automatic wait_idle;
    int n;
    for (n = 0; n < 300; n++)
    begin
      bus(1'b0, OFS_STAT, '0);
      if (got[SB_BUSY] === 1'b0 && got[SB_TXE] === 1'b1) break;
    end
    if (n >= 300) hang("idle");
    repeat (16) @(posedge clk);
  endtask
  // select leads the first clock edge
  // external master frame, 200 ns serial period, data set on falling edges
  task automatic slave_byte(input logic [7:0] b);
    fsi <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 7; i >= 0; i--)
    begin
      sci <= 1'b0;
      srx <= b[i];
      repeat (4) @(posedge clk);
      sci <= 1'b1;
      repeat (4) @(posedge clk);
    end
    srx <= ~b[0];
    repeat (4) @(posedge clk);
    fsi <= 1'b1;
  endtask
  // *****
  // tests
  // *****
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk(32'({sclk, fso, txd, txoe, ckoe}), 32'h0000_000B, "reset pins");
    rdv(OFS_CTRL, 32'h0000_0700, "ctrl reset");
    rdv(OFS_DIV, 32'h0000_0004, "div reset");
    rdv(OFS_STAT, 32'h0000_0001, "stat reset");
    rdv(4'h2, 32'h0000_0000, "unmapped");
    bus(1'b1, OFS_DIV, 32'h0000_0001);
    rdv(OFS_DIV, 32'h0000_0002, "div floor");
    bus(1'b1, OFS_DIV, 32'h0000_0004);
    $display("test registers done");
    bus(1'b1, OFS_CTRL, 32'h0000_0F0F);
    repeat (2) @(posedge clk);
    chk(32'({sclk, fso, ckoe}), 32'h0000_0006, "mode 11 idle");
    nrise = 0;
    bus(1'b1, OFS_DATA, 32'h0000_8421);
    bus(1'b1, OFS_DATA, 32'h0000_1E7F);
    wait_idle;
    chk(cap, 32'h8421_1E7F, "mode 11 tx");
    chk(32'(nrise), 32'h0000_0001, "mode 11 frames");
    rdv(OFS_DATA, 32'h0000_A5C3, "mode 11 rx 1");
    rdv(OFS_DATA, 32'h0000_3C5A, "mode 11 rx 2");
    $display("test mode 11 done");
    cw = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      nr = k ? 5'h10 : 5'h04;
      bus(1'b1, OFS_CTRL, k ? 32'h0000_0F13 : 32'h0000_0313);
      nrise = 0;
      for (int j = 0; j <= k; j++) bus(1'b1, OFS_DATA, 32'h0000_00C6);
      wait_idle;
      chk(32'(nrise), 32'h0000_0001, "cw frames");
      chk(32'(8'(cap >> (nr + 1))), 32'h0000_00C6, "cw command");
      chk(32'(sclk), 32'h0000_0000, "cw idle clock");
      for (int j = 0; j <= k; j++) rdv(OFS_DATA, resp >> (32 - nr), "cw resp");
      $display("test control word %0d done", nr);
    end
    slv = 1'b1;
    bus(1'b1, OFS_CTRL, 32'h0000_070D);
    slave_byte(8'h96);
    repeat (8) @(posedge clk);
    chk(32'(ckoe), 32'h0000_0001, "slave clock pad");
    rdv(OFS_DATA, 32'h0000_0096, "slave rx");
    $display("test slave done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
